// *** rtl/rohd_pkg.sv ***
// Operation
// - Hold output for minimum closed/open interval.
// - During hold ignore alarms, freeze delay counter.
// - Delay counter counts up while logic one.
// - Counter counts down to zero while zero.
// - Nonzero delay postpones change until counter reaches it.
// - Close delay for on, open delay off.
// - Closed hold energized, open hold de-energized.
// - Alarms use threshold plus or minus hysteresis.
// - Combine channel alarms by OR or AND.
// - Channel source: alarm one, two, both.
// - Normally-open closes on one; normally-closed inverts.
// - Zero delay switches immediately.
package rohd_pkg;
    // -------------------------------------------------------------
    // Sizes and timing
    // -------------------------------------------------------------
    localparam int CHANNELS     = 4;
    localparam int VALUE_W      = 16;
    localparam int TIME_W       = 16;
    localparam int CLK_HZ       = 20000000;
    localparam int TICK_MS      = 100;
    localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_W       = 21;
    localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;
    localparam logic [TIME_W-1:0] TIME_ONE  = 16'h0001;

    // -------------------------------------------------------------
    // Encodings
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        ROHD_SRC_AL1  = 2'h0,
        ROHD_SRC_AL2  = 2'h1,
        ROHD_SRC_BOTH = 2'h2,
        ROHD_SRC_NONE = 2'h3
    } rohd_src_type;

    typedef enum logic [1:0] {
        ROHD_IDLE = 2'h0,
        ROHD_HOLD = 2'h1
    } rohd_state_type;

    // One alarm comparator setting
    typedef struct packed {
        logic                      overMode;
        logic signed [VALUE_W-1:0] threshold;
        logic        [VALUE_W-1:0] hysteresis;
    } rohd_alarm_cfg_type;

    // Output timing settings, in ticks
    typedef struct packed {
        logic [TIME_W-1:0] closeDelay;
        logic [TIME_W-1:0] openDelay;
        logic [TIME_W-1:0] closedHold;
        logic [TIME_W-1:0] openHold;
    } rohd_timing_type;
endpackage

// *** rtl/rohd_alarm.sv ***
`timescale 1ns/1ps
module rohd_alarm
    import rohd_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstN,
    input  wire logic                      enable,
    // Measurement and settings
    input  wire logic signed [VALUE_W-1:0] value,
    input  wire rohd_alarm_cfg_type        cfg,
    // Alarm state
    output logic                           alarm
);
    logic signed [VALUE_W+1:0] upper;
    logic signed [VALUE_W+1:0] lower;
    logic signed [VALUE_W+1:0] valueWide;
    logic                      alarm_reg;

    // Widened bounds so threshold +/- hysteresis cannot wrap
    assign upper = {{2{cfg.threshold[VALUE_W-1]}}, cfg.threshold}
                 + $signed({2'h0, cfg.hysteresis});
    assign lower = {{2{cfg.threshold[VALUE_W-1]}}, cfg.threshold}
                 - $signed({2'h0, cfg.hysteresis});
    assign valueWide = {{2{value[VALUE_W-1]}}, value};

    // Hysteresis band keeps state between the two bounds
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            alarm_reg <= 1'b0;
        end else if (enable) begin
            if (cfg.overMode) begin
                if (valueWide >= upper) alarm_reg <= 1'b1;
                else if (valueWide <= lower) alarm_reg <= 1'b0;
            end else begin
                if (valueWide <= lower) alarm_reg <= 1'b1;
                else if (valueWide >= upper) alarm_reg <= 1'b0;
            end
        end
    end

    assign alarm = alarm_reg;
endmodule

// *** rtl/rohd_relay_ctrl.sv ***
`timescale 1ns/1ps
module rohd_relay_ctrl
    import rohd_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      clkEn,
    // Measurements, one per channel
    input  wire logic signed [VALUE_W-1:0] value [CHANNELS],
    // Alarm settings per channel
    input  wire rohd_alarm_cfg_type        alarm1Cfg [CHANNELS],
    input  wire rohd_alarm_cfg_type        alarm2Cfg [CHANNELS],
    input  wire rohd_src_type              source [CHANNELS],
    // Output settings
    input  wire logic                      logicAnd,
    input  wire logic                      normClosed,
    input  wire rohd_timing_type           timing,
    // Relay and status
    output logic                           relayClosed,
    output logic                           logicResult,
    output logic                           holdActive,
    output logic [CHANNELS-1:0]            chanAlarm
);
    // -------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------
    logic rstSync1_reg;
    logic rstN_reg;

    // Two stages keep the release clear of the clock edge; the
    // synchroniser ignores the clock enable so reset always ends
    // Asynchronous assert, synchronous release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync1_reg <= 1'b0;
            rstN_reg     <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstN_reg     <= rstSync1_reg;
        end
    end

    // -------------------------------------------------------------
    // Alarms and channel source
    // -------------------------------------------------------------
    logic [CHANNELS-1:0] al1;
    logic [CHANNELS-1:0] al2;
    logic [CHANNELS-1:0] chanState;
    logic [CHANNELS-1:0] attached;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            logic selState;

            rohd_alarm u_al1 (
                .clk    (clk),
                .rstN   (rstN_reg),
                .enable (clkEn),
                .value  (value[ch]),
                .cfg    (alarm1Cfg[ch]),
                .alarm  (al1[ch])
            );
            rohd_alarm u_al2 (
                .clk    (clk),
                .rstN   (rstN_reg),
                .enable (clkEn),
                .value  (value[ch]),
                .cfg    (alarm2Cfg[ch]),
                .alarm  (al2[ch])
            );
            // Source selection; NONE detaches the channel
            always_comb begin
                selState = 1'b0;
                unique case (source[ch])
                    ROHD_SRC_AL1:  selState = al1[ch];
                    ROHD_SRC_AL2:  selState = al2[ch];
                    ROHD_SRC_BOTH: selState = al1[ch] & al2[ch];
                    ROHD_SRC_NONE: selState = 1'b0;
                endcase
            end

            // One driver per bit keeps the shared vectors clean
            assign chanState[ch] = selState;
            assign attached[ch]  = (source[ch] != ROHD_SRC_NONE);
        end
    endgenerate

    // -------------------------------------------------------------
    // Logic function and wanted relay state
    // -------------------------------------------------------------
    logic combined;
    logic wantClosed;

    // AND over attached channels only; no attached channel gives zero
    assign combined = logicAnd ? ((&(chanState | ~attached)) & (|attached))
                               : (|chanState);
    assign wantClosed = combined ^ normClosed;

    // -------------------------------------------------------------
    // Tenth-second tick
    // -------------------------------------------------------------
    logic [TICK_W-1:0] tickCnt_reg;
    logic              tick;

    // Prescaler is not cleared by relay changes, so the first step
    // of any delay or hold may come up to one tick early; that
    // jitter stays below the resolution of the settings.
    // A low clock enable stretches the ticks with everything else.
    assign tick = (tickCnt_reg == TICK_W'(TICK_CYCLES - 1));

    // Free-running prescaler, one tick per 0.1 s
    always_ff @(posedge clk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            tickCnt_reg <= '0;
        end else if (clkEn) begin
            tickCnt_reg <= tick ? '0 : tickCnt_reg + TICK_W'(1);
        end
    end

    // -------------------------------------------------------------
    // Hold and delay control
    // -------------------------------------------------------------
    rohd_state_type    state_reg;
    logic [TIME_W-1:0] holdCnt_reg;
    logic [TIME_W-1:0] delayCnt_reg;
    logic [TIME_W-1:0] delayLimit;
    logic [TIME_W-1:0] newHold;
    logic              relay_reg;
    logic              switchNow;

    // Counter runs toward the delay of the pending direction
    assign delayLimit = wantClosed ? timing.closeDelay : timing.openDelay;
    assign newHold    = relay_reg ? timing.openHold : timing.closedHold;
    // Zero delay switches at once; otherwise wait for counter
    assign switchNow  = (wantClosed != relay_reg) &&
                        ((delayLimit == TIME_ZERO) ||
                         (tick && delayCnt_reg + TIME_ONE >= delayLimit));

    // While holding, neither alarms nor the delay counter are looked
    // at, so a short glitch cannot bounce the contact.
    // Limitation: the counter only climbs while the logic result is
    // one, so a change toward the logic-zero side should use delays
    // of at most one tick in that direction.
    // Relay, hold timer and debounce counter
    always_ff @(posedge clk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            state_reg    <= ROHD_IDLE;
            holdCnt_reg  <= TIME_ZERO;
            delayCnt_reg <= TIME_ZERO;
            relay_reg    <= 1'b0;
        end else if (clkEn) begin
            unique case (state_reg)
                ROHD_HOLD: begin
                    // Alarms ignored and delay counter frozen until hold expires
                    if (tick) begin
                        if (holdCnt_reg <= TIME_ONE) state_reg <= ROHD_IDLE;
                        holdCnt_reg <= holdCnt_reg - TIME_ONE;
                    end
                end
                ROHD_IDLE: begin
                    if (switchNow) begin
                        relay_reg    <= wantClosed;
                        delayCnt_reg <= TIME_ZERO;
                        holdCnt_reg  <= newHold;
                        if (newHold != TIME_ZERO) state_reg <= ROHD_HOLD;
                    end else if (tick) begin
                        if (combined) begin
                            if (delayCnt_reg < delayLimit)
                                delayCnt_reg <= delayCnt_reg + TIME_ONE;
                        end else if (delayCnt_reg != TIME_ZERO) begin
                            delayCnt_reg <= delayCnt_reg - TIME_ONE;
                        end
                    end
                end
                default: state_reg <= ROHD_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // Registered outputs
    // -------------------------------------------------------------
    // Contact drive, one clock behind the decision
    always_ff @(posedge clk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            relayClosed <= 1'b0;
        end else if (clkEn) begin
            relayClosed <= relay_reg;
        end
    end

    // Combined logic result for status
    always_ff @(posedge clk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            logicResult <= 1'b0;
        end else if (clkEn) begin
            logicResult <= combined;
        end
    end

    // Hold indicator, lines up with the contact it protects
    always_ff @(posedge clk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            holdActive <= 1'b0;
        end else if (clkEn) begin
            holdActive <= (state_reg == ROHD_HOLD);
        end
    end

    // Per-channel alarm state after source selection
    always_ff @(posedge clk or negedge rstN_reg) begin
        if (!rstN_reg) begin
            chanAlarm <= '0;
        end else if (clkEn) begin
            chanAlarm <= chanState;
        end
    end
endmodule

// *** test/rohd_load_model.sv ***
`timescale 1ns/1ps
module rohd_load_model (
    // Relay contact
    input  wire logic clk,
    input  wire logic contact,
    // Supply state of the load
    output logic      energized
);
    // Load draws current only through a closed contact, one clock behind
    always_ff @(posedge clk) begin
        energized <= contact;
    end
endmodule

// *** test/rohd_rly_sva.sv ***
`timescale 1ns/1ps
module rohd_rly_sva
    import rohd_pkg::*;
(
    // Clock and settings
    input wire logic                clk,
    input wire logic                reset_n,
    input wire rohd_src_type        source [CHANNELS],
    input wire logic                logicAnd,
    input wire logic                normClosed,
    input wire rohd_timing_type     timing,
    // Relay and status
    input wire logic [CHANNELS-1:0] chanAlarm,
    input wire logic                logicResult,
    input wire logic                relayClosed,
    input wire logic                holdActive
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [CHANNELS-1:0] att;
    logic                early;
    int                  cyc;
    // Attached channels; no tick can fall while early holds
    for (genvar i = 0; i < CHANNELS; i++) begin
        assign att[i] = source[i] != ROHD_SRC_NONE;
    end
    assign early = cyc < TICK_CYCLES - 8;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            cyc <= 0;
        else if (early)
            cyc <= cyc + 1;
    end
    AST_COMB: assert property ($stable({att, chanAlarm, logicAnd})[*3] |->
        logicResult == (logicAnd ? att != '0 && (chanAlarm & att) == att : |(chanAlarm & att)))
        else $error("bad logic result");
    AST_FOLLOW: assert property ((timing == '0 && !holdActive && $stable(logicResult)
        && $stable(normClosed))[*6] |-> relayClosed == (logicResult ^ normClosed))
        else $error("relay not following logic");
    AST_WAIT_CLOSE: assert property ((!relayClosed && timing.closeDelay != 0
        && early)[*3] |=> !relayClosed) else $error("close delay ignored");
    AST_WAIT_OPEN: assert property ((relayClosed && timing.openDelay != 0
        && early)[*3] |=> relayClosed) else $error("open delay ignored");
    AST_FREEZE: assert property (holdActive[*3] |-> $stable(relayClosed))
        else $error("contact moved in hold");
    AST_CLOSE_HOLD: assert property ($rose(relayClosed) && timing.closedHold != 0
        |-> ##[0:1] holdActive) else $error("no hold after closing");
    AST_OPEN_HOLD: assert property ($fell(relayClosed) && timing.openHold != 0
        |-> ##[0:1] holdActive) else $error("no hold after opening");
    AST_NO_HOLD: assert property ($rose(holdActive) |->
        (timing.closedHold | timing.openHold) != 0) else $error("hold with zero time");
    COV_CLOSE: cover property ($rose(relayClosed));
    COV_HOLD: cover property ($rose(holdActive));
    COV_AND: cover property (logicAnd && logicResult);
endmodule

bind rohd_relay_ctrl rohd_rly_sva chk_u (.clk, .reset_n, .source, .logicAnd, .normClosed,
    .timing, .chanAlarm, .logicResult, .relayClosed, .holdActive);

// *** test/rohd_relay_ctrl_test.sv ***
`timescale 1ns/1ps
module rohd_relay_ctrl_test
    import rohd_pkg::*;
;
    logic                      clk = 1'b0;
    logic                      reset_n = 1'b0;
    logic signed [VALUE_W-1:0] value [CHANNELS];
    rohd_alarm_cfg_type        alarm1Cfg [CHANNELS];
    rohd_alarm_cfg_type        alarm2Cfg [CHANNELS];
    rohd_src_type              source [CHANNELS];
    logic                      logicAnd = 1'b0;
    logic                      normClosed = 1'b0;
    logic                      clkEn = 1'b1;
    rohd_timing_type           timing = '0;
    logic                      relayClosed, logicResult, holdActive, loadOn;
    logic [CHANNELS-1:0]       chanAlarm, ch;
    int                        fail_count = 0;
    int                        comparisons = 0;
    int                        t1, t2, v;
    int                        tab [6] = '{50, 110, 91, 90, 109, 110};
    logic [5:0]                tabExp = 6'h26;
    rohd_relay_ctrl dut_u (.clk, .reset_n, .clkEn, .value, .alarm1Cfg, .alarm2Cfg,
        .source, .logicAnd, .normClosed, .timing, .relayClosed, .logicResult, .holdActive,
        .chanAlarm);
    rohd_load_model load_u (.clk, .contact(relayClosed), .energized(loadOn));
    // Clock, and a watchdog far past the few hundred cycles of tests
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
    // Detached channels are masked out of every comparison
    function automatic logic [3:0] attached();
        for (int c = 0; c < CHANNELS; c++) attached[c] = source[c] != ROHD_SRC_NONE;
    endfunction
    function automatic logic [6:0] expOut(input logic h, input logic [3:0] a);
        logic r;
        r = logicAnd ? (attached() != 4'h0 && (a & attached()) == attached()) : |(a & attached());
        return {h, r ^ normClosed, r, a & attached()};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    // Settle, then compare load, hold, contact, logic and alarms
    task automatic settle(input logic [6:0] e);
        repeat (8) @(negedge clk);
        check({loadOn, holdActive, relayClosed, logicResult, chanAlarm & attached()}, {e[5], e});
    endtask
    task automatic print_verdict();
        $display("%0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        for (int c = 0; c < CHANNELS; c++) begin
            value[c] = '0;
            alarm1Cfg[c] = '0;
            alarm2Cfg[c] = '0;
            source[c] = ROHD_SRC_NONE;
        end
        void'($urandom(32'hf229));
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        // Unselected comparator disagrees at least at every expected zero, so a wrong source shows
        for (int m = 0; m < 2; m++) begin
            source[0] = m ? ROHD_SRC_AL2 : ROHD_SRC_AL1;
            alarm1Cfg[0] = {1'b1, 16'h0064, 16'h000a};
            alarm2Cfg[0] = m ? {1'b0, 16'h0064, 16'h000a} : {1'b1, 16'h8ad0, 16'h0000};
            for (int i = 0; i < 6; i++) begin
                v = m ? 200 - tab[i] : tab[i];
                value[0] = 16'(v);
                settle(expOut(1'b0, {3'h0, tabExp[i]}));
            end
        end
        $display("hysteresis test done");
        // Odd values never sit on an even threshold, so no bound is ambiguous
        for (int n = 0; n < 40; n++) begin
            logicAnd = n < 2 ? 1'b1 : 1'($urandom_range(1));
            normClosed = 1'($urandom_range(1));
            for (int c = 0; c < CHANNELS; c++) begin
                t1 = 2 * $urandom_range(2000) - 2000;
                t2 = 2 * $urandom_range(2000) - 2000;
                v = 2 * $urandom_range(3000) - 2999;
                alarm1Cfg[c] = {1'b1, 16'(t1), 16'h0000};
                alarm2Cfg[c] = {1'b1, 16'(t2), 16'h0000};
                value[c] = 16'(v);
                source[c] = rohd_src_type'(n == 0 ? 3 : n == 1 ? 2 : $urandom_range(3));
                ch[c] = source[c] == ROHD_SRC_AL1 ? v > t1 : source[c] == ROHD_SRC_AL2 ? v > t2
                    : v > t1 && v > t2;
            end
            settle(expOut(1'b0, ch));
        end
        $display("random logic test done");
        // No tick falls in this run, so any nonzero delay or hold must stall
        for (int c = 1; c < CHANNELS; c++) source[c] = ROHD_SRC_NONE;
        source[0] = ROHD_SRC_AL1;
        normClosed = 1'b0;
        value[0] = 16'hf448;
        settle(7'h00);
        // Low clock enable must hide a new measurement entirely
        clkEn = 1'b0;
        value[0] = 16'h0bb8;
        settle(7'h00);
        clkEn = 1'b1;
        timing.closeDelay = 16'h0001;
        value[0] = 16'h0bb8;
        settle(7'h11);
        timing.closeDelay = 16'h0000;
        settle(7'h31);
        timing.openDelay = 16'h0001;
        value[0] = 16'hf448;
        settle(7'h20);
        timing.openDelay = 16'h0000;
        settle(7'h00);
        timing.closedHold = 16'h0001;
        value[0] = 16'h0bb8;
        settle(7'h71);
        value[0] = 16'hf448;
        settle(7'h60);
        $display("delay and hold test done");
        print_verdict();
    end
endmodule
